//--- acsc_consts.svh
`ifndef ACSC_CONSTS_SVH
`define ACSC_CONSTS_SVH

// ==========================================================
// Register offsets from the board base address
`define ACSC_ADDR_W          4
`define ACSC_OFF_CMD_ONE     4'h0
`define ACSC_OFF_ADC_CLEAR   4'h1

// ==========================================================
// Field positions of acquisition_command_one
`define ACSC_BIT_SCAN_OFF_N  7
`define ACSC_BIT_TIMER_IRQ   6
`define ACSC_BIT_EXT_IRQ     5
`define ACSC_BIT_RESULT_IRQ  4
`define ACSC_CHAN_MSB        3
`define ACSC_CHAN_LSB        0

// ==========================================================
// Reset values
`define ACSC_CMD_ONE_RESET   8'h80
`define ACSC_CHAN_RESET      4'h0

`endif

//--- acsc_pkg.sv
package acsc_pkg;

    // ==========================================================
    // Types
    typedef logic [3:0] acsc_chan_t;
    typedef logic [7:0] acsc_byte_t;

    // Scan set-up progress of the command register
    typedef enum logic [1:0] {
        ACSC_SINGLE,
        ACSC_LOADED,
        ACSC_SCANNING
    } acsc_mode_t;

    // ==========================================================
    // Next channel of a scan; direction high counts up to the limit
    function automatic acsc_chan_t acsc_next_chan(input acsc_chan_t cur,
                                                  input acsc_chan_t lim,
                                                  input logic       up);
        acsc_chan_t res;
        if (up) begin
            res = (cur >= lim) ? 4'h0 : 4'(cur + 4'h1);
        end else begin
            res = (cur == 4'h0) ? lim : 4'(cur - 4'h1);
        end
        return res;
    endfunction

endpackage

//--- acsc_scan_if.sv
`timescale 1ns/1ns

// ==========================================================
// Link between the command register and the scan counter
interface acsc_scan_if;
    logic               load;
    acsc_pkg::acsc_chan_t load_value;
    logic               step;
    logic               direction;
    acsc_pkg::acsc_chan_t limit;
    acsc_pkg::acsc_chan_t count;

    modport ctrl (output load, output load_value, output step, output direction,
                  output limit, input count);
    modport cnt  (input load, input load_value, input step, input direction,
                  input limit, output count);
endinterface

//--- acsc_scan_counter.sv
`timescale 1ns/1ns
`include "acsc_consts.svh"

module acsc_scan_counter (
    input  wire logic   i_clk,
    input  wire logic   i_sys_rst,
    acsc_scan_if.cnt    scan
);

    acsc_pkg::acsc_chan_t count;
    acsc_pkg::acsc_chan_t next_count;

    // ==========================================================
    // Counter next value: a load beats a step
    always_comb begin
        next_count = count;
        if (scan.load) begin
            next_count = scan.load_value;
        end else if (scan.step) begin
            next_count = acsc_pkg::acsc_next_chan(count, scan.limit,
                                                  scan.direction);
        end
    end

    // Counter register
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            count <= `ACSC_CHAN_RESET;
        end else begin
            count <= next_count;
        end
    end

    assign scan.count = count;

    // ==========================================================
    // Checks
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);

    down_step_a: assert property (
        scan.step && !scan.load && !scan.direction && count != 4'h0
        |=> count == 4'($past(count) - 4'h1))
        else $error("Down scan did not step one channel lower");

    down_wrap_a: assert property (
        scan.step && !scan.load && !scan.direction && count == 4'h0
        |=> count == $past(scan.limit))
        else $error("Down scan did not wrap to the selected channel");

    up_wrap_a: assert property (
        scan.step && !scan.load && scan.direction && count >= scan.limit
        |=> count == 4'h0)
        else $error("Up scan did not wrap to channel zero");

    count_hold_a: assert property (
        !scan.step && !scan.load |=> $stable(count))
        else $error("Scan counter moved without a step or load");

endmodule

//--- acsc_command_reg.sv
`timescale 1ns/1ns
`include "acsc_consts.svh"

// What this block does
// - The command register is an 8-bit write-only register at offset zero, not readable there.
// - Bit 7 is scan-off (active low), bits 6..4 are the three irq enables, bits 3..0 the channel.
// - After reset the scan-off bit is one, so single-channel acquisition is selected.
// - With scan-off at zero the channels from the selected one to zero are sampled in turn, in the order set by the sequence direction.
// - With scan-off at one only the selected channel is sampled for the whole acquisition.
// - A write with scan-off high loads the counter; a matching write with it low starts the scan.
// - Reads may return anything in don't-care positions and software ignores them.
// - Values written into don't-care positions change no hardware state.
// - A write to a register without fields is a strobe whatever its data is.
// - The sequence direction picks scanning up from zero or down from the selected channel.
module acsc_command_reg (
    input  wire logic                      i_clk,
    input  wire logic                      i_sys_rst,
    input  wire logic                      i_wr_strobe,
    input  wire logic [`ACSC_ADDR_W-1:0]   i_addr,
    input  wire logic [7:0]                i_wdata,
    input  wire logic                      i_sequence_direction,
    input  wire logic                      i_conv_done,
    output logic                           o_multichannel_scan_off_n,
    output logic                           o_timer_irq_enable,
    output logic                           o_external_irq_enable,
    output logic                           o_result_ready_irq_enable,
    output logic [3:0]                     o_channel_select,
    output logic [3:0]                     o_mux_select,
    output logic                           o_scanning,
    output logic                           o_adc_clear
);

    acsc_pkg::acsc_byte_t  cmd;
    acsc_pkg::acsc_byte_t  next_cmd;
    acsc_pkg::acsc_mode_t  mode;
    acsc_pkg::acsc_mode_t  next_mode;
    logic                  adc_clear;
    logic                  next_adc_clear;
    logic                  wr_cmd;
    logic                  wr_clear;
    logic                  chan_match;
    acsc_pkg::acsc_chan_t  wr_chan;
    acsc_pkg::acsc_chan_t  sel_chan;

    acsc_scan_if scan ();

    // ==========================================================
    // Address decode
    // Only writes are decoded; reads at offset zero belong to the status
    // logic, so no read path exists here.
    assign wr_cmd   = i_wr_strobe && (i_addr == `ACSC_OFF_CMD_ONE);
    assign wr_clear = i_wr_strobe && (i_addr == `ACSC_OFF_ADC_CLEAR);
    assign wr_chan  = i_wdata[`ACSC_CHAN_MSB:`ACSC_CHAN_LSB];
    assign sel_chan = cmd[`ACSC_CHAN_MSB:`ACSC_CHAN_LSB];
    assign chan_match = (wr_chan == sel_chan);

    // ==========================================================
    // Command register and scan set-up progress
    // Every bit of this register is defined, so a write stores all eight;
    // other offsets leave it alone.
    always_comb begin
        next_cmd  = cmd;
        next_mode = mode;
        if (wr_cmd) begin
            next_cmd = i_wdata;
            if (i_wdata[`ACSC_BIT_SCAN_OFF_N]) begin
                next_mode = acsc_pkg::ACSC_LOADED;
            end else begin
                next_mode = acsc_pkg::ACSC_SCANNING;
            end
        end
    end

    // Register state; power-on value keeps single-channel mode
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            cmd  <= `ACSC_CMD_ONE_RESET;
            mode <= acsc_pkg::ACSC_SINGLE;
        end else begin
            cmd  <= next_cmd;
            mode <= next_mode;
        end
    end

    // ==========================================================
    // Clear strobe: data is ignored, any write fires it
    always_comb begin
        next_adc_clear = wr_clear;
    end

    // Clear strobe register, one cycle wide
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            adc_clear <= 1'b0;
        end else begin
            adc_clear <= next_adc_clear;
        end
    end

    // ==========================================================
    // Scan counter control
    // A load write always reloads. An enable write reloads too unless it
    // follows a load of the same channel; this way a lone enable write
    // still scans from a defined channel instead of a stale count.
    assign scan.load       = wr_cmd && (i_wdata[`ACSC_BIT_SCAN_OFF_N] ||
                             !(mode == acsc_pkg::ACSC_LOADED && chan_match));
    assign scan.load_value = wr_chan;
    assign scan.step       = (mode == acsc_pkg::ACSC_SCANNING) && i_conv_done;
    assign scan.direction  = i_sequence_direction;
    assign scan.limit      = sel_chan;

    acsc_scan_counter u_counter (
        .i_clk     (i_clk),
        .i_sys_rst (i_sys_rst),
        .scan      (scan)
    );

    // ==========================================================
    // Outputs; the mux is a plain select between two registers
    assign o_multichannel_scan_off_n = cmd[`ACSC_BIT_SCAN_OFF_N];
    assign o_timer_irq_enable        = cmd[`ACSC_BIT_TIMER_IRQ];
    assign o_external_irq_enable     = cmd[`ACSC_BIT_EXT_IRQ];
    assign o_result_ready_irq_enable = cmd[`ACSC_BIT_RESULT_IRQ];
    assign o_channel_select          = sel_chan;
    assign o_scanning                = (mode == acsc_pkg::ACSC_SCANNING);
    assign o_mux_select = o_scanning ? scan.count : sel_chan;
    assign o_adc_clear  = adc_clear;

    // ==========================================================
    // Checks
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);

    sequence s_load_write;
        wr_cmd && i_wdata[`ACSC_BIT_SCAN_OFF_N];
    endsequence

    sequence s_enable_same;
        wr_cmd && !i_wdata[`ACSC_BIT_SCAN_OFF_N] && chan_match;
    endsequence

    reset_value_a: assert property (
        $fell(i_sys_rst) |-> cmd == `ACSC_CMD_ONE_RESET && !o_scanning)
        else $error("Command register left reset with a wrong value");

    write_fields_a: assert property (
        wr_cmd |=> o_multichannel_scan_off_n == $past(i_wdata[7])
                   && o_channel_select == $past(wr_chan))
        else $error("Command write did not land in its fields");

    other_offset_a: assert property (
        !wr_cmd |=> $stable(cmd))
        else $error("Command register changed without a write to it");

    clear_pulse_a: assert property (
        wr_clear |=> o_adc_clear ##1 (o_adc_clear == $past(wr_clear)))
        else $error("Clear strobe did not follow its write");

    single_mux_a: assert property (
        o_multichannel_scan_off_n |-> o_mux_select == o_channel_select && !o_scanning)
        else $error("Single-channel mode did not drive the selected channel");

    scan_mode_a: assert property (
        o_scanning |-> !o_multichannel_scan_off_n && o_mux_select == scan.count)
        else $error("Scanning without the counter on the multiplexer");

    scan_setup_a: assert property (
        s_load_write ##1 s_enable_same |=> o_scanning
                                           && o_mux_select == $past(wr_chan, 2))
        else $error("Load then enable did not scan from the loaded channel");

    no_step_idle_a: assert property (
        !o_scanning && !scan.load |=> $stable(scan.count))
        else $error("Scan counter stepped while not scanning");

    // ==========================================================
    // Loads, scan stepping, irq bits and clear strobe; the counter is watched directly at scan.count
    sequence s_conv_while_scanning;
        o_scanning && i_conv_done && !wr_cmd;
    endsequence

    irq_fields_a: assert property (
        wr_cmd |=> o_timer_irq_enable == $past(i_wdata[`ACSC_BIT_TIMER_IRQ])
                   && o_external_irq_enable == $past(i_wdata[`ACSC_BIT_EXT_IRQ])
                   && o_result_ready_irq_enable == $past(i_wdata[`ACSC_BIT_RESULT_IRQ]))
        else $error("Command write did not land in the irq enable bits");

    load_counter_a: assert property (
        s_load_write |=> scan.count == $past(wr_chan) && !o_scanning)
        else $error("Load write did not load the scan counter");

    lone_enable_a: assert property (
        wr_cmd && !i_wdata[`ACSC_BIT_SCAN_OFF_N]
        && !(mode == acsc_pkg::ACSC_LOADED && chan_match)
        |=> o_scanning && scan.count == $past(wr_chan))
        else $error("Enable write without a matching load did not start at its channel");

    // A reload must win over a finished conversion, or the scan starts one channel off
    load_wins_a: assert property (
        o_scanning && i_conv_done && wr_cmd |=> scan.count == $past(wr_chan))
        else $error("Conversion step overrode a reloading command write");

    step_hold_a: assert property (
        o_scanning && !i_conv_done && !wr_cmd |=> $stable(scan.count))
        else $error("Scan counter moved without a finished conversion");

    up_step_a: assert property (
        o_scanning && i_conv_done && !wr_cmd && i_sequence_direction
        && scan.count < o_channel_select
        |=> scan.count == 4'($past(scan.count) + 4'h1))
        else $error("Up scan did not step one channel higher");

    scan_wrap_a: assert property (
        s_conv_while_scanning ##0 (!i_sequence_direction && scan.count == 4'h0)
        |=> scan.count == o_channel_select)
        else $error("Down scan did not wrap back to the selected channel");

    clear_quiet_a: assert property (
        !wr_clear |=> !o_adc_clear)
        else $error("Clear strobe fired without a write to its offset");

endmodule

//--- tb.sv
`timescale 1ns/1ns
`include "acsc_consts.svh"

// ==========================================================
// Top of the bench for the command register block
module tb;
    logic       i_clk;
    logic       i_sys_rst;
    logic       i_wr_strobe;
    logic [3:0] i_addr;
    logic [7:0] i_wdata;
    logic       i_sequence_direction;
    logic       i_conv_done;
    logic       o_multichannel_scan_off_n;
    logic       o_timer_irq_enable;
    logic       o_external_irq_enable;
    logic       o_result_ready_irq_enable;
    logic [3:0] o_channel_select;
    logic [3:0] o_mux_select;
    logic       o_scanning;
    logic       o_adc_clear;
    logic [7:0] cmd;
    int         err_count;
    int         total_checks;

    // Command fields gathered back into register order
    assign cmd = {o_multichannel_scan_off_n, o_timer_irq_enable, o_external_irq_enable,
                  o_result_ready_irq_enable, o_channel_select};

    acsc_command_reg u_acsc_command_reg (
        .i_clk                     (i_clk),
        .i_sys_rst                 (i_sys_rst),
        .i_wr_strobe               (i_wr_strobe),
        .i_addr                    (i_addr),
        .i_wdata                   (i_wdata),
        .i_sequence_direction      (i_sequence_direction),
        .i_conv_done               (i_conv_done),
        .o_multichannel_scan_off_n (o_multichannel_scan_off_n),
        .o_timer_irq_enable        (o_timer_irq_enable),
        .o_external_irq_enable     (o_external_irq_enable),
        .o_result_ready_irq_enable (o_result_ready_irq_enable),
        .o_channel_select          (o_channel_select),
        .o_mux_select              (o_mux_select),
        .o_scanning                (o_scanning),
        .o_adc_clear               (o_adc_clear)
    );

    // ==========================================================
    // Shared tasks
    task automatic chk(input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask

    task automatic tally_and_finish();
        if (err_count == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // One write, then an idle cycle so the strobe is seen low again
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        i_wr_strobe = 1'b1;
        i_addr = a;
        i_wdata = d;
        @(negedge i_clk);
        i_wr_strobe = 1'b0;
        @(negedge i_clk);
    endtask

    // Load write and enable write in consecutive cycles, the tightest spacing allowed
    task automatic wr_pair(input logic [7:0] a, input logic [7:0] b);
        i_wr_strobe = 1'b1;
        i_addr = `ACSC_OFF_CMD_ONE;
        i_wdata = a;
        @(negedge i_clk);
        i_wdata = b;
        @(negedge i_clk);
        i_wr_strobe = 1'b0;
        @(negedge i_clk);
    endtask

    task automatic step();
        i_conv_done = 1'b1;
        @(negedge i_clk);
        i_conv_done = 1'b0;
        @(negedge i_clk);
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_single();
        for (int i = 0; i < 3; i++) begin
            wr(`ACSC_OFF_CMD_ONE, 8'h80 | (8'h10 << i));
            chk(8'h80 | (8'h10 << i), cmd);
        end
        wr(`ACSC_OFF_CMD_ONE, 8'hfa);
        chk(8'hfa, cmd);
        step();
        chk(8'h0a, {4'h0, o_mux_select});
        chk(8'h00, {7'h00, o_scanning});
    endtask

    task automatic t_scan(input logic dir, input logic [3:0] sel, input logic [15:0] seq);
        i_sequence_direction = dir;
        wr_pair({4'h8, sel}, {4'h0, sel});
        chk(8'h01, {7'h00, o_scanning});
        chk({4'h0, sel}, {4'h0, o_mux_select});
        for (int i = 3; i >= 0; i--) begin
            step();
            chk({4'h0, seq[i*4 +: 4]}, {4'h0, o_mux_select});
        end
    endtask

    // Clear strobe ignores its data; a stray offset leaves the register alone
    task automatic t_clear();
        for (int i = 0; i < 2; i++) begin
            i_wr_strobe = 1'b1;
            i_addr = `ACSC_OFF_ADC_CLEAR;
            i_wdata = (i == 0) ? 8'h00 : 8'hff;
            @(negedge i_clk);
            i_wr_strobe = 1'b0;
            chk(8'h01, {7'h00, o_adc_clear});
            @(negedge i_clk);
            chk(8'h00, {7'h00, o_adc_clear});
            chk(8'h85, cmd);
        end
        wr(4'h3, 8'h00);
        chk(8'h85, cmd);
    endtask

    // Enable writes without a matching load start at their own channel;
    // a reloading write beats a conversion that lands in the same cycle
    task automatic t_lone_enable();
        i_sequence_direction = 1'b0;
        wr(`ACSC_OFF_CMD_ONE, 8'h86);
        wr(`ACSC_OFF_CMD_ONE, 8'h04);
        chk(8'h14, {3'h0, o_scanning, o_mux_select});
        i_wr_strobe = 1'b1;
        i_wdata = 8'h07;
        i_conv_done = 1'b1;
        @(negedge i_clk);
        i_wr_strobe = 1'b0;
        i_conv_done = 1'b0;
        @(negedge i_clk);
        chk(8'h17, {3'h0, o_scanning, o_mux_select});
        step();
        chk(8'h16, {3'h0, o_scanning, o_mux_select});
    endtask

    task automatic t_stop_reset();
        i_sequence_direction = 1'b0;
        wr(`ACSC_OFF_CMD_ONE, 8'h85);
        chk(8'h00, {7'h00, o_scanning});
        chk(8'h05, {4'h0, o_mux_select});
        t_clear();
        wr_pair(8'h84, 8'h04);
        i_sys_rst = 1'b1;
        repeat (2) @(negedge i_clk);
        i_sys_rst = 1'b0;
        chk(`ACSC_CMD_ONE_RESET, cmd);
        chk(8'h00, {3'h0, o_scanning, o_mux_select});
    endtask

    // ==========================================================
    // Clock, watchdog and main sequence
    initial begin
        i_clk = 1'b0;
        forever #50 i_clk = ~i_clk;
    end

    // Bounded run: a hang counts as a mismatch
    initial begin
        repeat (3000) @(posedge i_clk);
        err_count++;
        tally_and_finish();
    end

    initial begin
        err_count = 0;
        total_checks = 0;
        i_sys_rst = 1'b1;
        i_wr_strobe = 1'b0;
        i_addr = 4'h0;
        i_wdata = 8'h00;
        i_sequence_direction = 1'b0;
        i_conv_done = 1'b0;
        repeat (2) @(negedge i_clk);
        i_sys_rst = 1'b0;
        chk(`ACSC_CMD_ONE_RESET, cmd);
        chk(8'h00, {3'h0, o_scanning, o_mux_select});
        t_single();
        t_scan(1'b0, 4'h3, 16'h2103);
        t_scan(1'b1, 4'h2, 16'h0120);
        t_lone_enable();
        t_stop_reset();
        tally_and_finish();
    end
endmodule
